// >>> logic/acc_pkg.sv
// Package with register map, field positions and reset values of the comparator control block
package acc_pkg;
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h50;
	localparam logic [7:0] ADDR_BUF_DISABLE = 8'h7f;
	localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h80;
	localparam logic [7:0] ADDR_CONV_SETUP = 8'h84;
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP_SEL = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_IRQ_FLAG = 4;
	localparam int BIT_IRQ_ENABLE = 3;
	localparam int BIT_CAPTURE_EN = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_NEG_PIN_OFF = 1;
	localparam int BIT_POS_PIN_OFF = 0;
	localparam int BIT_MUX_ENABLE = 6;
	localparam int BIT_CONV_ENABLE = 7;
	localparam int BIT_CONV_PWR_REDUCE = 6;
	localparam int BIT_CHAN_HIGH = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BUF_DISABLE_RESET = 8'h00;
	localparam logic [7:0] BUF_DISABLE_MASK = 8'h03;
	localparam logic [7:0] CONV_CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CONV_SETUP_RESET = 8'h00;
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
endpackage : acc_pkg

// >>> logic/acc_comparator_ctrl.sv
// Control and status logic around the on-chip analog comparator
//
// Summary of operation
// - Result reads one when positive exceeds negative
// - Mux on, converter off: 4-bit channel index
// - Otherwise dedicated negative pin drives negative input
// - Bandgap select bit picks reference for positive
// - Raw output synchronised, one to two cycles
// - Flag set on selected output event
// - Request only when flag, enable, global set
// - Flag clears on vector taken or write-one
// - Modes: toggle, reserved, falling, rising
// - Power-off bit removes comparator power
// - Capture enable routes result to timer
// - Buffer disable forces pin input zero
// - Converter mux needs power-reduce bit clear
`timescale 1ns/1ns
module acc_comparator_ctrl (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [31:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_wb_we,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_comp_raw,
	input wire logic i_pos_pin_digital,
	input wire logic i_neg_pin_digital,
	input wire logic i_global_irq_enable,
	input wire logic i_vector_taken,
	output logic o_irq,
	output logic o_comp_power_off,
	output logic o_pos_bandgap_sel,
	output logic o_neg_use_mux,
	output logic [3:0] o_neg_channel,
	output logic o_capture_trigger,
	output logic o_pos_buf_off,
	output logic o_neg_buf_off,
	output logic o_pos_pin_read,
	output logic o_neg_pin_read
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] bufdis_reg, bufdis_next;
	logic [7:0] convb_reg, convb_next;
	logic [7:0] setup_reg, setup_next;
	logic sync1_reg, sync2_reg, prev_reg;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic irq_reg, irq_next;
	logic [1:0] pin_s1_reg, pin_s2_reg;
	logic pos_read_reg, neg_read_reg;
	logic cap_reg, pwr_reg, bg_reg, mux_reg;
	logic [3:0] chan_reg;
	logic pwr_next, bg_next, mux_next, cap_next, pos_read_next, neg_read_next;
	logic [3:0] chan_next;
	logic event_hit;
	logic req;
	logic wr;

	// Byte 0 write helper with lane select
	function automatic logic [7:0] acc_wbyte(input logic [7:0] old, input logic [7:0] val, input logic lane);
		acc_wbyte = lane ? val : old;
	endfunction : acc_wbyte

	assign req = i_wb_cyc && i_wb_stb && !ack_reg;
	assign wr = req && i_wb_we && i_wb_sel[0];

	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			pin_s1_reg <= 2'h0;
			pin_s2_reg <= 2'h0;
		end else begin
			sync1_reg <= i_comp_raw;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			pin_s1_reg <= {i_neg_pin_digital, i_pos_pin_digital};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Event detect against previous synchronised value; reserved mode never fires
	always_comb begin
		unique case (ctrl_reg[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO])
			acc_pkg::MODE_TOGGLE: event_hit = sync2_reg != prev_reg;
			acc_pkg::MODE_RESERVED: event_hit = 1'b0;
			acc_pkg::MODE_FALL: event_hit = prev_reg && !sync2_reg;
			acc_pkg::MODE_RISE: event_hit = !prev_reg && sync2_reg;
		endcase
	end

	// Register writes; flag set beats any clear in the same cycle
	always_comb begin
		logic [7:0] wv;
		wv = acc_wbyte(8'h00, i_wb_dat[7:0], 1'b1);
		ctrl_next = ctrl_reg;
		bufdis_next = bufdis_reg;
		convb_next = convb_reg;
		setup_next = setup_reg;
		if (wr && i_wb_adr[7:0] == acc_pkg::ADDR_CTRL_STATUS) begin
			// Result bit is read-only and the flag is write-one-to-clear
			ctrl_next[7:6] = wv[7:6];
			ctrl_next[3:0] = wv[3:0];
			if (wv[acc_pkg::BIT_IRQ_FLAG]) begin
				ctrl_next[acc_pkg::BIT_IRQ_FLAG] = 1'b0;
			end
		end
		if (i_vector_taken) begin
			ctrl_next[acc_pkg::BIT_IRQ_FLAG] = 1'b0;
		end
		if (event_hit) begin
			ctrl_next[acc_pkg::BIT_IRQ_FLAG] = 1'b1;
		end
		ctrl_next[acc_pkg::BIT_RESULT] = 1'b0;
		if (wr && i_wb_adr[7:0] == acc_pkg::ADDR_BUF_DISABLE) begin
			bufdis_next = wv & acc_pkg::BUF_DISABLE_MASK;
		end
		if (wr && i_wb_adr[7:0] == acc_pkg::ADDR_CONV_CTRL_B) begin
			convb_next = acc_wbyte(convb_reg, wv, 1'b1);
		end
		if (wr && i_wb_adr[7:0] == acc_pkg::ADDR_CONV_SETUP) begin
			setup_next = acc_wbyte(setup_reg, wv, 1'b1);
		end
	end

	// Bus answer: registered ack one cycle after the request, zero for unmapped reads
	always_comb begin
		ack_next = req;
		rdat_next = 32'h00000000;
		if (req && !i_wb_we) begin
			unique case (i_wb_adr[7:0])
				acc_pkg::ADDR_CTRL_STATUS: rdat_next[7:0] = {ctrl_reg[7:6], sync2_reg, ctrl_reg[4:0]};
				acc_pkg::ADDR_BUF_DISABLE: rdat_next[7:0] = bufdis_reg;
				acc_pkg::ADDR_CONV_CTRL_B: rdat_next[7:0] = convb_reg;
				acc_pkg::ADDR_CONV_SETUP: rdat_next[7:0] = setup_reg;
				default: rdat_next = 32'h00000000;
			endcase
		end
		// Request only with flag, local enable and global enable
		irq_next = ctrl_next[acc_pkg::BIT_IRQ_FLAG] && ctrl_reg[acc_pkg::BIT_IRQ_ENABLE]
			&& i_global_irq_enable;
	end

	// Registered state of the register file and bus
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_reg <= acc_pkg::CTRL_RESET;
			bufdis_reg <= acc_pkg::BUF_DISABLE_RESET;
			convb_reg <= acc_pkg::CONV_CTRL_B_RESET;
			setup_reg <= acc_pkg::CONV_SETUP_RESET;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			bufdis_reg <= bufdis_next;
			convb_reg <= convb_next;
			setup_reg <= setup_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			irq_reg <= irq_next;
		end
	end

	// Next values of the analog steering and pin read-back flops
	always_comb begin
		pwr_next = ctrl_reg[acc_pkg::BIT_POWER_OFF];
		bg_next = ctrl_reg[acc_pkg::BIT_BANDGAP_SEL];
		// Converter mux only when enabled, converter off and not power-reduced
		mux_next = convb_reg[acc_pkg::BIT_MUX_ENABLE] && !setup_reg[acc_pkg::BIT_CONV_ENABLE]
			&& !setup_reg[acc_pkg::BIT_CONV_PWR_REDUCE];
		chan_next = {setup_reg[acc_pkg::BIT_CHAN_HIGH], setup_reg[2:0]};
		// Plain gated copy; the timer front end does its own noise filtering
		cap_next = ctrl_reg[acc_pkg::BIT_CAPTURE_EN] && sync2_reg;
		// A disabled buffer reads zero whatever the pin does
		pos_read_next = pin_s2_reg[0] && !bufdis_reg[acc_pkg::BIT_POS_PIN_OFF];
		neg_read_next = pin_s2_reg[1] && !bufdis_reg[acc_pkg::BIT_NEG_PIN_OFF];
	end

	// Steering registers; every steering output leaves a flip-flop
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pwr_reg <= 1'b0;
			bg_reg <= 1'b0;
			mux_reg <= 1'b0;
			chan_reg <= 4'h0;
			cap_reg <= 1'b0;
			pos_read_reg <= 1'b0;
			neg_read_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			bg_reg <= bg_next;
			mux_reg <= mux_next;
			chan_reg <= chan_next;
			cap_reg <= cap_next;
			pos_read_reg <= pos_read_next;
			neg_read_reg <= neg_read_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
	assign o_irq = irq_reg;
	assign o_comp_power_off = pwr_reg;
	assign o_pos_bandgap_sel = bg_reg;
	assign o_neg_use_mux = mux_reg;
	assign o_neg_channel = chan_reg;
	assign o_capture_trigger = cap_reg;
	assign o_pos_buf_off = bufdis_reg[acc_pkg::BIT_POS_PIN_OFF];
	assign o_neg_buf_off = bufdis_reg[acc_pkg::BIT_NEG_PIN_OFF];
	assign o_pos_pin_read = pos_read_reg;
	assign o_neg_pin_read = neg_read_reg;

	// Checks beside the logic
	chk_rise_sets_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == 2'h3 && !prev_reg && sync2_reg) |=> ctrl_reg[4])
		else $error("rising edge did not set flag");
	chk_reserved_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == 2'h1 && !ctrl_reg[4] && !wr && !i_vector_taken) |=> !ctrl_reg[4])
		else $error("reserved mode set flag");
	chk_irq_gating: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_irq |-> $past(ctrl_reg[3]) && $past(i_global_irq_enable))
		else $error("irq without enables");
	chk_vector_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_vector_taken && !event_hit) |=> !ctrl_reg[4])
		else $error("vector did not clear flag");
	chk_sync_latency: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(sync1_reg) |=> sync2_reg)
		else $error("sync latency wrong");
	chk_buf_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		bufdis_reg[0] && $past(bufdis_reg[0]) |-> !pos_read_reg)
		else $error("disabled pin reads one");
	chk_mux_select: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$past(setup_reg[7]) |-> !mux_reg)
		else $error("mux used while converter on");
	chk_reserved_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		bufdis_reg[7:2] == 6'h00 && ctrl_reg[5] == 1'b0)
		else $error("reserved bits set");
	chk_capture_route: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!$past(ctrl_reg[2]) |-> !cap_reg)
		else $error("capture routed while off");

	// Event checks: falling and rising modes fire on their own edge only, toggle on any change
	// Falling edge in falling mode must raise the flag
	chk_fall_sets_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == acc_pkg::MODE_FALL && prev_reg && !sync2_reg) |=> ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("falling edge did not set flag");
	// Any change in toggle mode must raise the flag
	chk_toggle_sets_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == acc_pkg::MODE_TOGGLE && sync2_reg != prev_reg) |=> ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("toggle did not set flag");
	// Without an event a clear flag stays clear
	chk_no_event_no_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!event_hit && !ctrl_reg[acc_pkg::BIT_IRQ_FLAG]) |=> !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("flag set without event");
	// A rising edge in falling mode leaves the flag alone
	chk_rise_ignored_fall: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == acc_pkg::MODE_FALL && !prev_reg && sync2_reg && !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		|=> !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("rising edge flagged in falling mode");
	// A falling edge in rising mode leaves the flag alone
	chk_fall_ignored_rise: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[1:0] == acc_pkg::MODE_RISE && prev_reg && !sync2_reg && !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		|=> !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("falling edge flagged in rising mode");

	// Flag clearing: write-one clears, write-zero keeps, set wins a tie
	chk_write_one_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr && i_wb_adr[7:0] == acc_pkg::ADDR_CTRL_STATUS && i_wb_dat[acc_pkg::BIT_IRQ_FLAG] && !event_hit)
		|=> !ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("write one did not clear flag");
	// A set flag survives anything but a clear request
	chk_flag_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctrl_reg[acc_pkg::BIT_IRQ_FLAG] && !i_vector_taken
		&& !(wr && i_wb_adr[7:0] == acc_pkg::ADDR_CTRL_STATUS && i_wb_dat[acc_pkg::BIT_IRQ_FLAG]))
		|=> ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("flag lost without clear");
	// Losing an event to a simultaneous clear would drop an interrupt
	chk_set_beats_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(event_hit && (i_vector_taken || wr)) |=> ctrl_reg[acc_pkg::BIT_IRQ_FLAG])
		else $error("clear beat a new event");

	// Request level is exactly flag, local enable and global enable
	chk_irq_exact: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_irq == (ctrl_reg[acc_pkg::BIT_IRQ_FLAG] && $past(ctrl_reg[acc_pkg::BIT_IRQ_ENABLE])
		&& $past(i_global_irq_enable)))
		else $error("irq level wrong");

	// Result path: second stage copies the first, read-back shows the second
	chk_sync_second: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		sync2_reg == $past(sync1_reg))
		else $error("second sync stage wrong");
	// Read data carries the synchronised result of the request cycle
	chk_result_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(req && !i_wb_we && i_wb_adr[7:0] == acc_pkg::ADDR_CTRL_STATUS)
		|=> o_wb_dat[acc_pkg::BIT_RESULT] == $past(sync2_reg))
		else $error("result bit read back wrong");
	// Unmapped reads must return zero
	chk_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(req && !i_wb_we && i_wb_adr[7:0] != acc_pkg::ADDR_CTRL_STATUS && i_wb_adr[7:0] != acc_pkg::ADDR_BUF_DISABLE
		&& i_wb_adr[7:0] != acc_pkg::ADDR_CONV_CTRL_B && i_wb_adr[7:0] != acc_pkg::ADDR_CONV_SETUP)
		|=> o_wb_dat == 32'h00000000)
		else $error("unmapped read not zero");

	// Control writes land; steering outputs follow their register bits one cycle later
	chk_ctrl_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr && i_wb_adr[7:0] == acc_pkg::ADDR_CTRL_STATUS) |=> ctrl_reg[7:6] == $past(i_wb_dat[7:6]))
		else $error("control write lost");
	// Power-off pin tracks its bit
	chk_power_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_comp_power_off == $past(ctrl_reg[acc_pkg::BIT_POWER_OFF]))
		else $error("power off does not follow bit");
	// Reference select pin tracks its bit
	chk_bandgap_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_pos_bandgap_sel == $past(ctrl_reg[acc_pkg::BIT_BANDGAP_SEL]))
		else $error("bandgap select does not follow bit");
	// Channel index is high select bit over low select bits
	chk_channel_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_neg_channel == {$past(setup_reg[acc_pkg::BIT_CHAN_HIGH]), $past(setup_reg[2:0])})
		else $error("channel index wrong");
	// Mux is used whenever all its conditions hold
	chk_mux_selects: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$past(convb_reg[acc_pkg::BIT_MUX_ENABLE] && !setup_reg[acc_pkg::BIT_CONV_ENABLE]
		&& !setup_reg[acc_pkg::BIT_CONV_PWR_REDUCE]) |-> o_neg_use_mux)
		else $error("mux not used when selected");
	// Without the enable the dedicated pin stays in use
	chk_mux_needs_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!$past(convb_reg[acc_pkg::BIT_MUX_ENABLE]) |-> !o_neg_use_mux)
		else $error("mux used without enable");
	// A power-reduced converter mux is never borrowed
	chk_mux_power_reduce: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$past(setup_reg[acc_pkg::BIT_CONV_PWR_REDUCE]) |-> !o_neg_use_mux)
		else $error("mux used while power reduced");
	// Capture line carries the result while routed
	chk_capture_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$past(ctrl_reg[acc_pkg::BIT_CAPTURE_EN]) |-> o_capture_trigger == $past(sync2_reg))
		else $error("capture line does not follow result");

	// Buffer disable: written bits land, disabled pins read zero
	chk_bufdis_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr && i_wb_adr[7:0] == acc_pkg::ADDR_BUF_DISABLE) |=> bufdis_reg[1:0] == $past(i_wb_dat[1:0]))
		else $error("buffer disable write lost");
	// Negative pin reads zero while its buffer is off
	chk_neg_buf_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		bufdis_reg[acc_pkg::BIT_NEG_PIN_OFF] && $past(bufdis_reg[acc_pkg::BIT_NEG_PIN_OFF]) |-> !neg_read_reg)
		else $error("disabled negative pin reads one");
	// An enabled buffer passes the synchronised pin level
	chk_pos_read_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!$past(bufdis_reg[acc_pkg::BIT_POS_PIN_OFF]) |-> o_pos_pin_read == $past(pin_s2_reg[0]))
		else $error("enabled positive pin read wrong");
endmodule : acc_comparator_ctrl

// >>> tb/acc_analog_model.sv
// Behavioural analog side: inputs, comparator core and pin levels
`timescale 1ns/1ns
module acc_analog_model #(
	parameter int BANDGAP_MV = 1100
) (
	input wire logic i_pos_bandgap_sel,
	input wire logic i_neg_use_mux,
	input wire logic [3:0] i_neg_channel,
	input wire logic i_comp_power_off,
	input wire logic signed [31:0] i_pos_mv,
	input wire logic signed [31:0] i_neg_mv,
	output logic o_comp_raw,
	output logic o_pos_pin_digital,
	output logic o_neg_pin_digital
);
	int pos_v, neg_v;
	// Unpowered core settles low; channel n sits at 100n+50 mV
	always_comb begin
		pos_v = i_pos_bandgap_sel ? BANDGAP_MV : i_pos_mv;
		neg_v = i_neg_use_mux ? 100 * int'(i_neg_channel) + 50 : i_neg_mv;
		o_comp_raw = !i_comp_power_off && (pos_v > neg_v);
		o_pos_pin_digital = i_pos_mv > 2500;
		o_neg_pin_digital = i_neg_mv > 2500;
	end
endmodule : acc_analog_model

// >>> tb/tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
module tb_top;
	logic i_sys_clk, i_rstn, req, we, gie, vec, ack, irq, pwr, bg, mux, cap, pbo, nbo, prd, nrd, raw, pdig, ndig;
	logic [31:0] adr, wdat, rdat;
	logic [3:0] sel, chan;
	logic [7:0] q;
	logic [31:0] e;
	int pos_mv, neg_mv, fail_count, n_tests, seed, m, k;
	acc_comparator_ctrl i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(req), .i_wb_stb(req), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_comp_raw(raw), .i_pos_pin_digital(pdig), .i_neg_pin_digital(ndig), .i_global_irq_enable(gie),
		.i_vector_taken(vec), .o_irq(irq), .o_comp_power_off(pwr), .o_pos_bandgap_sel(bg), .o_neg_use_mux(mux),
		.o_neg_channel(chan), .o_capture_trigger(cap), .o_pos_buf_off(pbo), .o_neg_buf_off(nbo),
		.o_pos_pin_read(prd), .o_neg_pin_read(nrd));
	acc_analog_model i_far (.i_pos_bandgap_sel(bg), .i_neg_use_mux(mux), .i_neg_channel(chan),
		.i_comp_power_off(pwr), .i_pos_mv(pos_mv), .i_neg_mv(neg_mv), .o_comp_raw(raw),
		.o_pos_pin_digital(pdig), .o_neg_pin_digital(ndig));
	// Clock and hang guard
	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		wrap_up();
	end
	task wrap_up;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle; read data taken at the ack edge
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		req <= 1'b1;
		we <= w;
		adr <= {24'h0, a};
		wdat <= {24'h0, d};
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		if (n >= 16) begin
			fail_count++;
			wrap_up();
		end
		q = rdat[7:0];
		req <= 1'b0;
	endtask : wb
	// Sync plus flag settle within four edges
	task set_pos(input int v);
		@(posedge i_sys_clk);
		pos_mv <= v;
		repeat (4) @(posedge i_sys_clk);
	endtask : set_pos
	function automatic logic evt(int md, logic p, logic c);
		case (md)
			0: return p != c;
			2: return p && !c;
			3: return !p && c;
			default: return 1'b0;
		endcase
	endfunction : evt
	initial begin
		seed = 32'h398f;
		{fail_count, n_tests, pos_mv, neg_mv} = {32'h0, 32'h0, 32'h0, 32'd1000};
		{i_rstn, req, we, gie, vec, adr, wdat, sel} = {5'h0, 64'h0, 4'h1};
		repeat (8) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		wb(8'h50, 1'b0, 8'h00);
		chk(q, 8'h00);
		wb(8'h7f, 1'b1, 8'hff);
		wb(8'h7f, 1'b0, 8'h00);
		chk(q, 8'h03);
		set_pos(3000);
		chk({4'h0, pbo, nbo, prd, nrd}, 8'h0c);
		wb(8'h7f, 1'b1, 8'h00);
		repeat (3) @(posedge i_sys_clk);
		chk({4'h0, pbo, nbo, prd, nrd}, 8'h02);
		// Every mode, both edges; interrupt stays off while modes change
		for (m = 0; m < 4; m++) begin
			wb(8'h50, 1'b1, 8'h10 | 8'(m));
			for (k = 0; k < 2; k++) begin
				set_pos(k ? 3000 : 0);
				wb(8'h50, 1'b0, 8'h00);
				chk(q & 8'h30, {2'h0, k[0], evt(m, !k[0], k[0]), 4'h0});
				wb(8'h50, 1'b1, 8'h10 | 8'(m));
			end
		end
		wb(8'h50, 1'b1, 8'h08);
		set_pos(0);
		chk({7'h0, irq}, 8'h00);
		@(posedge i_sys_clk) gie <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		chk({7'h0, irq}, 8'h01);
		wb(8'h50, 1'b0, 8'h00);
		chk(q & 8'h10, 8'h10);
		@(posedge i_sys_clk) vec <= 1'b1;
		@(posedge i_sys_clk) vec <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		chk({7'h0, irq}, 8'h00);
		wb(8'h50, 1'b1, 8'h00);
		for (m = 0; m < 10; m++) begin
			e = $random(seed);
			wb(8'h80, 1'b1, {1'b0, e[0], 6'h0});
			wb(8'h84, 1'b1, {e[1], e[2], e[5:0]});
			repeat (2) @(posedge i_sys_clk);
			chk({3'h0, mux, chan}, {3'h0, e[0] & ~e[1] & ~e[2], e[5], e[2:0]});
		end
		wb(8'h80, 1'b1, 8'h00);
		wb(8'h50, 1'b1, 8'h64);
		repeat (4) @(posedge i_sys_clk);
		chk({5'h0, pwr, bg, cap}, 8'h03);
		wb(8'h50, 1'b0, 8'h00);
		chk(q & 8'he4, 8'h64);
		wb(8'h50, 1'b1, 8'h80);
		repeat (4) @(posedge i_sys_clk);
		chk({5'h0, pwr, bg, cap}, 8'h04);
		@(posedge i_sys_clk) sel <= 4'h0;
		wb(8'h7f, 1'b1, 8'h03);
		@(posedge i_sys_clk) sel <= 4'h1;
		wb(8'h7f, 1'b0, 8'h00);
		chk(q, 8'h00);
		wb(8'h10, 1'b1, 8'hff);
		wb(8'h10, 1'b0, 8'h00);
		chk(q, 8'h00);
		wrap_up();
	end
endmodule : tb_top
